// file: core/lui_regs.svh
// register map, reset values and bit positions of the line unit interrupt masks
`ifndef LUI_REGS_SVH
`define LUI_REGS_SVH

`define LUI_ADDR_W          12
`define LUI_DATA_W          32
`define LUI_GRP_W           8

`define LUI_OFF_MASK0       12'h000
`define LUI_OFF_MASK1       12'h004
`define LUI_OFF_MASK2       12'h008
`define LUI_OFF_EDGE0       12'h00C
`define LUI_OFF_EDGE1       12'h010
`define LUI_OFF_EDGE2       12'h014
`define LUI_OFF_ISTS0       12'h018
`define LUI_OFF_ISTS1       12'h01C
`define LUI_OFF_ISTS2       12'h020
`define LUI_OFF_STAT0       12'h024
`define LUI_OFF_STAT1       12'h028
`define LUI_OFF_STAT2       12'h02C

`define LUI_VALID0          8'hFF
`define LUI_VALID1          8'hE3
`define LUI_VALID2          8'h3F
`define LUI_RST_MASK0       8'hFF
`define LUI_RST_MASK1       8'hE3
`define LUI_RST_MASK2       8'h3F
`define LUI_RST_EDGE        8'h00
`define LUI_RST_ISTS        8'h00

`define LUI_B0_WAVEFORM     7
`define LUI_B0_TX_JFIFO     6
`define LUI_B0_RX_JFIFO     5
`define LUI_B0_OVERCUR      4
`define LUI_B0_TXCLK_MISS   3
`define LUI_B0_TX_LOS       2
`define LUI_B0_SYS_LOS      1
`define LUI_B0_LINE_LOS     0
`define LUI_B1_SYS_AIS      7
`define LUI_B1_LINE_AIS     6
`define LUI_B1_PAT_SYNC     5
`define LUI_B1_IB_ACT       1
`define LUI_B1_IB_DEACT     0
`define LUI_B2_SYS_BPV      5
`define LUI_B2_LINE_BPV     4
`define LUI_B2_SYS_EXZ      3
`define LUI_B2_LINE_EXZ     2
`define LUI_B2_PAT_ERR      1
`define LUI_B2_CNT_OVF      0

`endif

// file: core/lui_pkg.sv
// types shared by the line unit interrupt mask files
package lui_pkg;

	typedef logic [7:0] lui_grp_t;

	typedef enum {
		LUI_REG_MASK0,
		LUI_REG_MASK1,
		LUI_REG_MASK2,
		LUI_REG_EDGE0,
		LUI_REG_EDGE1,
		LUI_REG_EDGE2,
		LUI_REG_ISTS0,
		LUI_REG_ISTS1,
		LUI_REG_ISTS2,
		LUI_REG_STAT0,
		LUI_REG_STAT1,
		LUI_REG_STAT2,
		LUI_REG_NONE
	} lui_reg_t;

endpackage : lui_pkg

// file: core/lui_irq_group.sv
// one group of eight sticky interrupt status bits with edge selection
`timescale 1ns/1ns
`include "lui_regs.svh"
module lui_irq_group (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire lui_pkg::lui_grp_t status,
	input  wire lui_pkg::lui_grp_t edge_sel,
	input  wire lui_pkg::lui_grp_t valid,
	input  wire lui_pkg::lui_grp_t clr,
	output lui_pkg::lui_grp_t      ists
);
	import lui_pkg::*;

	lui_grp_t prev_r;
	lui_grp_t ists_r;
	lui_grp_t evt;

	// prev starts at zero, so a condition already high at release counts as a rise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_r <= `LUI_RST_ISTS;
		end else begin
			prev_r <= status;
		end
	end

	always_comb begin
		evt = ((status & ~prev_r) | (~status & prev_r & edge_sel)) & valid;
	end

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ists_r <= `LUI_RST_ISTS;
		end else begin
			ists_r <= (ists_r & ~clr) | evt;
		end
	end

	assign ists = ists_r;

endmodule : lui_irq_group

// file: core/lui_top.sv
// per-channel interrupt mask block with apb register access
`timescale 1ns/1ns
`include "lui_regs.svh"
module lui_top (
	input  wire logic                   CLK,
	input  wire logic                   RESET,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [`LUI_ADDR_W-1:0] PADDR,
	input  wire logic [`LUI_DATA_W-1:0] PWDATA,
	input  wire logic [3:0]             PSTRB,
	output logic [`LUI_DATA_W-1:0]      PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	input  wire lui_pkg::lui_grp_t      STAT_LINE_FAULTS,
	input  wire lui_pkg::lui_grp_t      STAT_ALARMS_CODES,
	input  wire lui_pkg::lui_grp_t      STAT_LINE_ERRORS,
	output logic                        IRQ
);
	import lui_pkg::*;

	function automatic lui_reg_t lui_decode(input logic [`LUI_ADDR_W-1:0] a);
		case (a)
			`LUI_OFF_MASK0: return LUI_REG_MASK0;
			`LUI_OFF_MASK1: return LUI_REG_MASK1;
			`LUI_OFF_MASK2: return LUI_REG_MASK2;
			`LUI_OFF_EDGE0: return LUI_REG_EDGE0;
			`LUI_OFF_EDGE1: return LUI_REG_EDGE1;
			`LUI_OFF_EDGE2: return LUI_REG_EDGE2;
			`LUI_OFF_ISTS0: return LUI_REG_ISTS0;
			`LUI_OFF_ISTS1: return LUI_REG_ISTS1;
			`LUI_OFF_ISTS2: return LUI_REG_ISTS2;
			`LUI_OFF_STAT0: return LUI_REG_STAT0;
			`LUI_OFF_STAT1: return LUI_REG_STAT1;
			`LUI_OFF_STAT2: return LUI_REG_STAT2;
			default:        return LUI_REG_NONE;
		endcase
	endfunction : lui_decode

	// raw status registers are read only; writing them is an error
	function automatic logic lui_read_only(input lui_reg_t r);
		case (r)
			LUI_REG_STAT0: return 1'b1;
			LUI_REG_STAT1: return 1'b1;
			LUI_REG_STAT2: return 1'b1;
			LUI_REG_NONE:  return 1'b1;
			default:       return 1'b0;
		endcase
	endfunction : lui_read_only

	lui_reg_t                sel_reg;
	logic                    setup_ph;
	logic                    access_ph;
	logic                    wr_en;
	logic [`LUI_DATA_W-1:0]  rd_value;
	logic [`LUI_DATA_W-1:0]  prdata_r;
	logic [`LUI_DATA_W-1:0]  prdata_nxt;
	logic                    pslverr_r;
	logic                    pslverr_nxt;

	lui_grp_t                mask0_r;
	lui_grp_t                mask1_r;
	lui_grp_t                mask2_r;
	lui_grp_t                edge0_r;
	lui_grp_t                edge1_r;
	lui_grp_t                edge2_r;
	lui_grp_t                ists0;
	lui_grp_t                ists1;
	lui_grp_t                ists2;
	lui_grp_t                clr0;
	lui_grp_t                clr1;
	lui_grp_t                clr2;
	lui_grp_t                pend0;
	lui_grp_t                pend1;
	lui_grp_t                pend2;
	lui_grp_t                wbyte;
	logic                    irq_r;
	logic                    irq_nxt;

	assign sel_reg   = lui_decode(PADDR);
	assign setup_ph  = PSEL & ~PENABLE;
	assign access_ph = PSEL & PENABLE;
	// only byte lane 0 carries register bits; a write without it changes nothing
	assign wr_en     = access_ph & PWRITE & PSTRB[0] & ~lui_read_only(sel_reg);
	assign wbyte     = PWDATA[`LUI_GRP_W-1:0];

	// zero wait states: read data is captured in the setup cycle
	assign PREADY    = access_ph;
	assign PSLVERR   = access_ph & pslverr_r;
	assign PRDATA    = prdata_r;

	always_comb begin
		rd_value = '0;
		case (sel_reg)
			LUI_REG_MASK0: rd_value[`LUI_GRP_W-1:0] = mask0_r;
			LUI_REG_MASK1: rd_value[`LUI_GRP_W-1:0] = mask1_r;
			LUI_REG_MASK2: rd_value[`LUI_GRP_W-1:0] = mask2_r;
			LUI_REG_EDGE0: rd_value[`LUI_GRP_W-1:0] = edge0_r;
			LUI_REG_EDGE1: rd_value[`LUI_GRP_W-1:0] = edge1_r;
			LUI_REG_EDGE2: rd_value[`LUI_GRP_W-1:0] = edge2_r;
			LUI_REG_ISTS0: rd_value[`LUI_GRP_W-1:0] = ists0;
			LUI_REG_ISTS1: rd_value[`LUI_GRP_W-1:0] = ists1;
			LUI_REG_ISTS2: rd_value[`LUI_GRP_W-1:0] = ists2;
			LUI_REG_STAT0: rd_value[`LUI_GRP_W-1:0] = STAT_LINE_FAULTS & `LUI_VALID0;
			LUI_REG_STAT1: rd_value[`LUI_GRP_W-1:0] = STAT_ALARMS_CODES & `LUI_VALID1;
			LUI_REG_STAT2: rd_value[`LUI_GRP_W-1:0] = STAT_LINE_ERRORS & `LUI_VALID2;
			default:       rd_value = '0;
		endcase
	end

	always_comb begin
		prdata_nxt  = prdata_r;
		pslverr_nxt = pslverr_r;
		if (setup_ph) begin
			prdata_nxt  = PWRITE ? '0 : rd_value;
			pslverr_nxt = PWRITE ? lui_read_only(sel_reg) : (sel_reg == LUI_REG_NONE);
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// mask registers; reserved positions are never stored and read zero
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			mask0_r <= `LUI_RST_MASK0;
		end else if (wr_en && sel_reg == LUI_REG_MASK0) begin
			mask0_r <= wbyte & `LUI_VALID0;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			mask1_r <= `LUI_RST_MASK1;
		end else if (wr_en && sel_reg == LUI_REG_MASK1) begin
			mask1_r <= wbyte & `LUI_VALID1;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			mask2_r <= `LUI_RST_MASK2;
		end else if (wr_en && sel_reg == LUI_REG_MASK2) begin
			mask2_r <= wbyte & `LUI_VALID2;
		end
	end

	// edge selection registers share the mask layout
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			edge0_r <= `LUI_RST_EDGE;
		end else if (wr_en && sel_reg == LUI_REG_EDGE0) begin
			edge0_r <= wbyte & `LUI_VALID0;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			edge1_r <= `LUI_RST_EDGE;
		end else if (wr_en && sel_reg == LUI_REG_EDGE1) begin
			edge1_r <= wbyte & `LUI_VALID1;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			edge2_r <= `LUI_RST_EDGE;
		end else if (wr_en && sel_reg == LUI_REG_EDGE2) begin
			edge2_r <= wbyte & `LUI_VALID2;
		end
	end

	// write one to clear; the clear lasts the single access cycle
	assign clr0 = (wr_en && sel_reg == LUI_REG_ISTS0) ? wbyte : '0;
	assign clr1 = (wr_en && sel_reg == LUI_REG_ISTS1) ? wbyte : '0;
	assign clr2 = (wr_en && sel_reg == LUI_REG_ISTS2) ? wbyte : '0;

	lui_irq_group u_grp0 (
		.clk      (CLK),
		.rst      (RESET),
		.status   (STAT_LINE_FAULTS),
		.edge_sel (edge0_r),
		.valid    (`LUI_VALID0),
		.clr      (clr0),
		.ists     (ists0)
	);

	lui_irq_group u_grp1 (
		.clk      (CLK),
		.rst      (RESET),
		.status   (STAT_ALARMS_CODES),
		.edge_sel (edge1_r),
		.valid    (`LUI_VALID1),
		.clr      (clr1),
		.ists     (ists1)
	);

	lui_irq_group u_grp2 (
		.clk      (CLK),
		.rst      (RESET),
		.status   (STAT_LINE_ERRORS),
		.edge_sel (edge2_r),
		.valid    (`LUI_VALID2),
		.clr      (clr2),
		.ists     (ists2)
	);

	// masking only gates the request: masked sources still record status
	always_comb begin
		pend0 = '0;
		pend1 = '0;
		pend2 = '0;
		pend0[`LUI_B0_WAVEFORM]   = ists0[`LUI_B0_WAVEFORM] & ~mask0_r[`LUI_B0_WAVEFORM];
		pend0[`LUI_B0_TX_JFIFO]   = ists0[`LUI_B0_TX_JFIFO] & ~mask0_r[`LUI_B0_TX_JFIFO];
		pend0[`LUI_B0_RX_JFIFO]   = ists0[`LUI_B0_RX_JFIFO] & ~mask0_r[`LUI_B0_RX_JFIFO];
		pend0[`LUI_B0_OVERCUR]    = ists0[`LUI_B0_OVERCUR] & ~mask0_r[`LUI_B0_OVERCUR];
		pend0[`LUI_B0_TXCLK_MISS] = ists0[`LUI_B0_TXCLK_MISS]
			& ~mask0_r[`LUI_B0_TXCLK_MISS];
		pend0[`LUI_B0_TX_LOS]     = ists0[`LUI_B0_TX_LOS] & ~mask0_r[`LUI_B0_TX_LOS];
		pend0[`LUI_B0_SYS_LOS]    = ists0[`LUI_B0_SYS_LOS] & ~mask0_r[`LUI_B0_SYS_LOS];
		pend0[`LUI_B0_LINE_LOS]   = ists0[`LUI_B0_LINE_LOS] & ~mask0_r[`LUI_B0_LINE_LOS];
		pend1[`LUI_B1_SYS_AIS]    = ists1[`LUI_B1_SYS_AIS] & ~mask1_r[`LUI_B1_SYS_AIS];
		pend1[`LUI_B1_LINE_AIS]   = ists1[`LUI_B1_LINE_AIS] & ~mask1_r[`LUI_B1_LINE_AIS];
		pend1[`LUI_B1_PAT_SYNC]   = ists1[`LUI_B1_PAT_SYNC] & ~mask1_r[`LUI_B1_PAT_SYNC];
		pend1[`LUI_B1_IB_ACT]     = ists1[`LUI_B1_IB_ACT] & ~mask1_r[`LUI_B1_IB_ACT];
		pend1[`LUI_B1_IB_DEACT]   = ists1[`LUI_B1_IB_DEACT] & ~mask1_r[`LUI_B1_IB_DEACT];
		pend2[`LUI_B2_SYS_BPV]    = ists2[`LUI_B2_SYS_BPV] & ~mask2_r[`LUI_B2_SYS_BPV];
		pend2[`LUI_B2_LINE_BPV]   = ists2[`LUI_B2_LINE_BPV] & ~mask2_r[`LUI_B2_LINE_BPV];
		pend2[`LUI_B2_SYS_EXZ]    = ists2[`LUI_B2_SYS_EXZ] & ~mask2_r[`LUI_B2_SYS_EXZ];
		pend2[`LUI_B2_LINE_EXZ]   = ists2[`LUI_B2_LINE_EXZ] & ~mask2_r[`LUI_B2_LINE_EXZ];
		pend2[`LUI_B2_PAT_ERR]    = ists2[`LUI_B2_PAT_ERR] & ~mask2_r[`LUI_B2_PAT_ERR];
		pend2[`LUI_B2_CNT_OVF]    = ists2[`LUI_B2_CNT_OVF] & ~mask2_r[`LUI_B2_CNT_OVF];
	end

	// registered so the pin is glitch free; costs one cycle of latency
	assign irq_nxt = |{pend0, pend1, pend2};

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign IRQ = irq_r;

endmodule : lui_top

// file: sim/lui_chk_props.sv
// concurrent checks on the ports of the line unit interrupt mask block
`timescale 1ns/1ns
module lui_chk
	import lui_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RESET,
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [11:0]       PADDR,
	input wire logic [31:0]       PWDATA,
	input wire logic [3:0]        PSTRB,
	input wire logic [31:0]       PRDATA,
	input wire logic              PREADY,
	input wire logic              PSLVERR,
	input wire lui_pkg::lui_grp_t STAT_LINE_FAULTS,
	input wire lui_pkg::lui_grp_t STAT_ALARMS_CODES,
	input wire lui_pkg::lui_grp_t STAT_LINE_ERRORS,
	input wire logic              IRQ
);
	logic     wr_acc;
	logic     rd_acc;
	logic     all_m;
	lui_grp_t m0_r;
	lui_grp_t m1_r;
	lui_grp_t m2_r;
	assign wr_acc = PSEL && PENABLE && PWRITE && PSTRB[0];
	assign rd_acc = PSEL && PENABLE && !PWRITE;
	assign all_m = (m0_r == 8'hFF) && (m1_r == 8'hE3) && (m2_r == 8'h3F);
	// shadow masks follow accepted writes so readback and gating can be judged
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			m0_r <= 8'hFF;
			m1_r <= 8'hE3;
			m2_r <= 8'h3F;
		end else if (wr_acc) begin
			if (PADDR == 12'h000) m0_r <= PWDATA[7:0];
			if (PADDR == 12'h004) m1_r <= PWDATA[7:0] & 8'hE3;
			if (PADDR == 12'h008) m2_r <= PWDATA[7:0] & 8'h3F;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	chk_mask_readback: assert property (
		rd_acc && PADDR inside {12'h000, 12'h004, 12'h008} |->
		PRDATA[7:0] == (PADDR == 12'h000 ? m0_r : PADDR == 12'h004 ? m1_r : m2_r))
		else $error("mask readback wrong");
	chk_rsv_second: assert property (rd_acc && PADDR == 12'h004 |-> PRDATA[4:2] == 3'h0)
		else $error("reserved bits of second mask read nonzero");
	chk_rsv_third: assert property (rd_acc && PADDR == 12'h008 |-> PRDATA[7:6] == 2'h0)
		else $error("reserved bits of third mask read nonzero");
	chk_irq_masked: assert property (all_m && $past(all_m) |-> !IRQ)
		else $error("interrupt raised while all sources masked");
	// sticky bit sets at the edge that sees the rise, the registered pin one edge later
	chk_irq_event: assert property (
		!wr_acc && |((STAT_LINE_FAULTS & ~$past(STAT_LINE_FAULTS)
		& ~m0_r) | (STAT_ALARMS_CODES & ~$past(STAT_ALARMS_CODES) & ~m1_r & 8'hE3)
		| (STAT_LINE_ERRORS & ~$past(STAT_LINE_ERRORS) & ~m2_r & 8'h3F)) |-> ##2 IRQ)
		else $error("unmasked event did not raise interrupt");
	chk_irq_fall: assert property ($fell(IRQ) |-> $past(wr_acc, 2))
		else $error("interrupt dropped without a write");
	chk_ready_now: assert property (PREADY == (PSEL && PENABLE))
		else $error("ready not in access phase");
	chk_err_unmap: assert property (PSEL && PENABLE && PADDR > 12'h02C |-> PSLVERR)
		else $error("unmapped access without error");
endmodule : lui_chk

bind lui_top lui_chk chk_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .STAT_LINE_FAULTS(STAT_LINE_FAULTS),
	.STAT_ALARMS_CODES(STAT_ALARMS_CODES), .STAT_LINE_ERRORS(STAT_LINE_ERRORS), .IRQ(IRQ));

// file: sim/tb_top.sv
// self-checking bench for the line unit interrupt mask block
`timescale 1ns/1ns
module tb_top;
	import lui_pkg::*;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready;
	logic        pslverr;
	logic        rerr;
	logic        irq;
	lui_grp_t    stat_r [3];
	int          error_cnt;
	int          num_checks;
	int          cyc;
	localparam logic [11:0] moff [3] = '{12'h000, 12'h004, 12'h008};
	localparam logic [11:0] ioff [3] = '{12'h018, 12'h01C, 12'h020};
	localparam lui_grp_t    valid [3] = '{8'hFF, 8'hE3, 8'h3F};

	lui_top dut_u (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .STAT_LINE_FAULTS(stat_r[0]), .STAT_ALARMS_CODES(stat_r[1]),
		.STAT_LINE_ERRORS(stat_r[2]), .IRQ(irq));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	task chk32(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t data %h expected %h", $time, got, exp);
		end
	endtask : chk32

	task chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	// holds the whole request until ready is seen high at a rising edge
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// only the bench timeout ends a wait for ready
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
		xfer(1'b0, a, 32'h0, 4'hF);
		chk32(rdat, exp);
		chk1(rerr, eerr);
	endtask : rd_chk

	task wr(input logic [11:0] a, input logic [31:0] d, input logic eerr);
		xfer(1'b1, a, d, 4'hF);
		chk1(rerr, eerr);
	endtask : wr

	// the sticky bit sets at the first edge and the registered output at the second; the third leaves margin
	task set_stat(input int g, input lui_grp_t v);
		@(posedge clk);
		stat_r[g] <= v;
		repeat (3) @(posedge clk);
	endtask : set_stat

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			$display("[ERR] %0t run did not finish", $time);
			complete_run();
		end
	end

	initial begin
		lui_grp_t bm;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		stat_r = '{8'h00, 8'h00, 8'h00};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int g = 0; g < 3; g++)
			rd_chk(moff[g], {24'h0, valid[g]}, 1'b0);
		$display("reset value test done");
		wr(12'h004, 32'hFFFFFFFF, 1'b0);
		rd_chk(12'h004, 32'h000000E3, 1'b0);
		wr(12'h008, 32'hFFFFFFFF, 1'b0);
		rd_chk(12'h008, 32'h0000003F, 1'b0);
		xfer(1'b1, 12'h000, 32'h0, 4'h0);
		rd_chk(12'h000, 32'h000000FF, 1'b0);
		rd_chk(12'h030, 32'h0, 1'b1);
		wr(12'h024, 32'h000000FF, 1'b1);
		$display("access test done");
		for (int g = 0; g < 3; g++) begin
			for (int b = 0; b < 8; b++) begin
				if (valid[g][b]) begin
					bm = lui_grp_t'(8'h01 << b);
					set_stat(g, bm);
					chk1(irq, 1'b0);
					rd_chk(ioff[g], {24'h0, bm}, 1'b0);
					wr(ioff[g], {24'h0, bm}, 1'b0);
					set_stat(g, 8'h00);
					rd_chk(ioff[g], 32'h0, 1'b0);
					wr(moff[g], {24'h0, valid[g] & ~bm}, 1'b0);
					set_stat(g, bm);
					chk1(irq, 1'b1);
					wr(moff[g], {24'h0, valid[g]}, 1'b0);
					repeat (2) @(posedge clk);
					chk1(irq, 1'b0);
					wr(ioff[g], {24'h0, bm}, 1'b0);
					set_stat(g, 8'h00);
				end
			end
		end
		$display("mask gating test done");
		wr(12'h014, 32'h00000001, 1'b0);
		rd_chk(12'h014, 32'h00000001, 1'b0);
		set_stat(2, 8'h01);
		rd_chk(12'h02C, 32'h00000001, 1'b0);
		wr(12'h020, 32'h00000001, 1'b0);
		set_stat(2, 8'h00);
		rd_chk(12'h020, 32'h00000001, 1'b0);
		$display("edge select test done");
		complete_run();
	end
endmodule : tb_top
